// [verilog/trgh_top.sv]
// trgh_top: health-gated true random generator output stage.
// assumes raw_bit arrives from the analogue source asynchronously; consumer is on clk_sys.
// Contract
// - test the source for total failure at start-up; deliver nothing on failure.
// - on total failure during run, block values built from later raw bits.
// - run the online statistical check at start-up and continuously while running; here it runs one window at start-up and one per retest interval.
// - keep output off until start-up check passes; suppress it on any defect.
// - re-trigger the online check periodically at a fixed interval.
// - internal bits must carry average entropy per bit above 0.997.
// - post-process raw entropy before values reach the consumer.
// - software test failure switches the generator off; no further values.
`timescale 1ns/1ps
module trgh_top (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic gen_enable,
	input wire logic sw_test_fail,
	input wire logic raw_bit,
	input wire logic rnd_ready,
	output logic rnd_valid,
	output logic [31:0] rnd_data,
	output logic rnd_fail,
	output logic rnd_busy
);
	trgh_pkg::trgh_state_t state_q, state_d;
	logic raw_meta_q, raw_sync_q, raw_prev_q;
	logic [trgh_pkg::STUCK_W-1:0] stuck_q;
	logic [trgh_pkg::WIN_W-1:0] win_q, ones_q;
	logic [trgh_pkg::RETEST_W-1:0] retest_q;
	logic testing_q, passed_q;
	logic pair_half_q, pair_first_q;
	logic [31:0] word_q;
	logic [4:0] bits_q;
	logic word_valid_q;
	logic fail_q, sw_off_q;
	logic out_valid_q;
	logic [31:0] out_data_q;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic fifo_in_ready;

	// pass/fail helper for the ones count at the online window end
	function automatic logic ones_ok(input logic [trgh_pkg::WIN_W-1:0] n);
		ones_ok = (n >= trgh_pkg::ONES_MIN_C) && (n <= trgh_pkg::ONES_MAX_C);
	endfunction

	// raw bit crosses in from the analogue source; two flops before any use
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			raw_meta_q <= 1'b0;
			raw_sync_q <= 1'b0;
			raw_prev_q <= 1'b0;
		end
		else
		begin
			raw_meta_q <= raw_bit;
			raw_sync_q <= raw_meta_q;
			raw_prev_q <= raw_sync_q;
		end
	end

	wire running = (state_q == trgh_pkg::TRGH_STARTUP) || (state_q == trgh_pkg::TRGH_RUN);
	// stuck source detect
	// 62 earlier equal pairs plus this one make 64 equal bits in a row
	wire stuck_hit = running && (raw_sync_q == raw_prev_q) && (stuck_q == trgh_pkg::STUCK_LIMIT_C - 7'h02);
	wire win_end = testing_q && (win_q == trgh_pkg::WIN_LAST_C);
	wire ones_next_ok = ones_ok(ones_q + {10'h000, raw_sync_q});
	wire online_bad = win_end && !ones_next_ok;
	wire online_good = win_end && ones_next_ok;
	wire retest_due = (state_q == trgh_pkg::TRGH_RUN) && (retest_q == '0);
	wire any_fail = stuck_hit || online_bad || sw_test_fail;

	// total-failure run-length counter, active on every raw bit while running
	always_ff @(posedge clk_sys)
	begin
		if (reset || !running || raw_sync_q != raw_prev_q)
			stuck_q <= '0;
		else if (stuck_q != trgh_pkg::STUCK_LIMIT_C)
			stuck_q <= stuck_q + 7'h01;
	end

	// online test window: counts ones over a fixed number of raw bits
	always_ff @(posedge clk_sys)
	begin
		if (reset || !running)
		begin
			testing_q <= 1'b0;
			win_q <= '0;
			ones_q <= '0;
		end
		else if (state_q == trgh_pkg::TRGH_STARTUP && !testing_q && !passed_q)
		begin
			testing_q <= 1'b1;
			win_q <= '0;
			ones_q <= '0;
		end
		else if (retest_due)
		begin
			testing_q <= 1'b1;
			win_q <= '0;
			ones_q <= '0;
		end
		else if (testing_q)
		begin
			testing_q <= !win_end;
			win_q <= win_q + 11'h001;
			ones_q <= ones_q + {10'h000, raw_sync_q};
		end
	end

	// start-up pass latch; cleared whenever the generator leaves running
	always_ff @(posedge clk_sys)
	begin
		if (reset || !running)
			passed_q <= 1'b0;
		else if (online_good)
			passed_q <= 1'b1;
	end

	// interval timer; reloads after each retrigger
	always_ff @(posedge clk_sys)
	begin
		if (reset || state_q != trgh_pkg::TRGH_RUN || retest_due)
			retest_q <= trgh_pkg::RETEST_W'(trgh_pkg::RETEST_CYC - 1);
		else
			retest_q <= retest_q - 15'h0001;
	end

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			trgh_pkg::TRGH_OFF:
				if (gen_enable && !sw_off_q)
					state_d = trgh_pkg::TRGH_STARTUP;
			trgh_pkg::TRGH_STARTUP:
				if (any_fail)
					state_d = trgh_pkg::TRGH_FAIL;
				else if (online_good)
					state_d = trgh_pkg::TRGH_RUN;
				else if (!gen_enable)
					state_d = trgh_pkg::TRGH_OFF;
			trgh_pkg::TRGH_RUN:
				if (any_fail)
					state_d = trgh_pkg::TRGH_FAIL;
				else if (!gen_enable)
					state_d = trgh_pkg::TRGH_OFF;
			trgh_pkg::TRGH_FAIL:
				if (!gen_enable && !sw_off_q)
					state_d = trgh_pkg::TRGH_OFF;
			default:
				state_d = trgh_pkg::TRGH_FAIL;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			state_q <= trgh_pkg::TRGH_OFF;
		else
			state_q <= state_d;
	end

	// software shutdown is sticky until reset
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			sw_off_q <= 1'b0;
		else if (sw_test_fail)
			sw_off_q <= 1'b1;
	end

	// failure flag: set on any failure while running wins, cleared only by reset or a re-enable from off
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			fail_q <= 1'b0;
		else if (any_fail && running)
			fail_q <= 1'b1;
		else if (state_q == trgh_pkg::TRGH_OFF && gen_enable && !sw_off_q)
			fail_q <= 1'b0;
	end

	// von neumann post-processing: pairs 01 -> 0, 10 -> 1, equal pairs dropped
	// debiasing keeps output entropy near one bit per bit for an independent source
	wire vn_fire = running && pair_half_q && (raw_sync_q != pair_first_q);
	always_ff @(posedge clk_sys)
	begin
		if (reset || !running)
		begin
			pair_half_q <= 1'b0;
			pair_first_q <= 1'b0;
			bits_q <= '0;
			word_q <= '0;
			word_valid_q <= 1'b0;
		end
		else
		begin
			pair_half_q <= !pair_half_q;
			pair_first_q <= raw_sync_q;
			word_valid_q <= vn_fire && (bits_q == trgh_pkg::BIT_LAST_C);
			if (vn_fire)
			begin
				word_q <= {word_q[30:0], pair_first_q};
				bits_q <= bits_q + 5'h01;
			end
		end
	end

	// flush discards every word that may hold post-failure raw bits
	wire fifo_flush = any_fail || !running;
	// only words made while passed enter the fifo
	wire fifo_push = word_valid_q && passed_q && !any_fail && fifo_in_ready; // a full queue drops the word
	// offer only while run still holds at the next edge, so a disable never leaves a word standing in off
	wire run_stay = (state_q == trgh_pkg::TRGH_RUN) && gen_enable && !any_fail;
	trgh_fifo #(
		.WIDTH(trgh_pkg::WORD_W),
		.DEPTH(trgh_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.flush(fifo_flush),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(word_q),
		.out_valid(fifo_out_valid),
		.out_ready(rnd_ready && !out_valid_q && run_stay),
		.out_data(fifo_out_data)
	);

	// output register: one word offered at a time, withdrawn on any failure
	wire take = rnd_ready && !out_valid_q && fifo_out_valid && run_stay;
	always_ff @(posedge clk_sys)
	begin
		if (reset || !run_stay)
		begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end
		else if (out_valid_q && rnd_ready)
			out_valid_q <= 1'b0;
		else if (take)
		begin
			out_valid_q <= 1'b1;
			out_data_q <= fifo_out_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rnd_busy <= 1'b0;
		else
			rnd_busy <= (state_d == trgh_pkg::TRGH_STARTUP) || testing_q;
	end
	assign rnd_valid = out_valid_q;
	assign rnd_data = out_data_q;
	assign rnd_fail = fail_q;

	// named sequences for the failure reaction
	sequence s_fail_seen;
		any_fail && running;
	endsequence
	sequence s_locked_out;
		!rnd_valid && rnd_fail;
	endsequence

	property p_no_output_before_pass;
		@(posedge clk_sys) disable iff (reset) rnd_valid |-> state_q == trgh_pkg::TRGH_RUN;
	endproperty
	a_no_output_before_pass: assert property (p_no_output_before_pass) else $error("output outside run");

	property p_fail_blocks;
		@(posedge clk_sys) disable iff (reset) s_fail_seen |=> s_locked_out;
	endproperty
	a_fail_blocks: assert property (p_fail_blocks) else $error("output after failure");

	property p_stuck_fails;
		@(posedge clk_sys) disable iff (reset) stuck_hit |=> state_q == trgh_pkg::TRGH_FAIL;
	endproperty
	a_stuck_fails: assert property (p_stuck_fails) else $error("stuck source not failed");

	property p_online_bad;
		@(posedge clk_sys) disable iff (reset) online_bad && running |=> state_q == trgh_pkg::TRGH_FAIL && rnd_fail;
	endproperty
	a_online_bad: assert property (p_online_bad) else $error("online defect not flagged");

	property p_startup_gate;
		@(posedge clk_sys) disable iff (reset) state_q == trgh_pkg::TRGH_STARTUP |=> !rnd_valid;
	endproperty
	a_startup_gate: assert property (p_startup_gate) else $error("output during start-up test");

	property p_retest;
		@(posedge clk_sys) disable iff (reset) retest_due && !any_fail && gen_enable |=> testing_q;
	endproperty
	a_retest: assert property (p_retest) else $error("periodic test not started");

	property p_push_passed;
		@(posedge clk_sys) disable iff (reset) fifo_push |-> passed_q && $past(vn_fire);
	endproperty
	a_push_passed: assert property (p_push_passed) else $error("word not from post-processing");

	property p_sw_off;
		@(posedge clk_sys) disable iff (reset) sw_test_fail |=> sw_off_q && !rnd_valid [*8];
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("generator kept running after software fail");

	property p_fail_flag;
		@(posedge clk_sys) disable iff (reset) state_q == trgh_pkg::TRGH_FAIL |-> rnd_fail;
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("fail flag low in failure");
endmodule

// [verilog/trgh_pkg.sv]
// trgh_pkg: constants for the health-gated true random generator wrapper.
// assumes one 25 MHz system clock and a synchronous active-high reset.
package trgh_pkg;
	localparam int unsigned CLK_MHZ = 25;
	// data path
	localparam int unsigned WORD_W = 32;
	localparam int unsigned FIFO_DEPTH = 32;
	// total-failure test: this many equal raw bits in a row count as a dead source
	localparam int unsigned STUCK_LIMIT = 64;
	// online test window, in raw bits, and the ones-count acceptance band
	localparam int unsigned WIN_BITS = 1024;
	localparam int unsigned ONES_MIN = 432;
	localparam int unsigned ONES_MAX = 592;
	// interval between periodic online tests, in microseconds
	localparam int unsigned RETEST_US = 1000;
	localparam int unsigned RETEST_CYC = RETEST_US * CLK_MHZ;
	// average entropy per internal bit must exceed this figure, in thousandths
	localparam int unsigned ENTROPY_MILLI = 997;
	// counter widths
	localparam int unsigned STUCK_W = 7;
	localparam int unsigned WIN_W = 11;
	localparam int unsigned RETEST_W = 15;
	localparam logic [STUCK_W-1:0] STUCK_LIMIT_C = 7'h40;
	localparam logic [WIN_W-1:0] WIN_LAST_C = 11'h3ff;
	localparam logic [WIN_W-1:0] ONES_MIN_C = 11'h1b0;
	localparam logic [WIN_W-1:0] ONES_MAX_C = 11'h250;
	localparam logic [4:0] BIT_LAST_C = 5'h1f;
	typedef enum logic [2:0] {
		TRGH_OFF,
		TRGH_STARTUP,
		TRGH_RUN,
		TRGH_FAIL
	} trgh_state_t;
endpackage

// [verilog/trgh_fifo.sv]
// trgh_fifo: synchronous FIFO with valid/ready on both sides.
// assumes producer and consumer share clk_sys; flush empties it in one cycle.
`timescale 1ns/1ps
module trgh_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 32
)(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;

	// status and head word
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[AW-1:0]];

	// storage write
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	// pointers; flush drops everything held
	always_ff @(posedge clk_sys)
	begin
		if (reset || flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + (AW+1)'(1);
			if (pop)
				rd_q <= rd_q + (AW+1)'(1);
		end
	end
endmodule

// [tb/trgh_consumer.sv]
// trgh_consumer: cpu-side reader model taking random words.
// assumes clk_sys shared with the generator; stall comes from the bench.
`timescale 1ns/1ps
module trgh_consumer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic stall,
	input wire logic rnd_valid,
	input wire logic [31:0] rnd_data,
	output logic rnd_ready,
	output int n_words,
	output logic [31:0] last_word
);
	// ready moves just after an edge, so a stall can hold an offered word
	always_ff @(posedge clk_sys)
	begin
		rnd_ready <= !reset && !stall;
		if (reset)
			n_words <= 0;
		else if (rnd_valid && rnd_ready)
		begin
			n_words <= n_words + 1;
			last_word <= rnd_data;
		end
	end
endmodule

// [tb/tb_trng_health_gated_output.sv]
// tb_trng_health_gated_output: scenario bench for the health-gated generator.
// assumes a raw source pattern made here and the consumer model beside it.
`timescale 1ns/1ps
module tb_trng_health_gated_output;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic gen_enable = 1'b0;
	logic sw_test_fail = 1'b0;
	logic raw_bit = 1'b0;
	logic stall = 1'b0;
	logic rnd_ready, rnd_valid, rnd_fail, rnd_busy;
	logic [31:0] rnd_data, last_word;
	int n_words, n_mismatch = 0, tests_run = 0, n;
	logic [3:0] pat = 4'ha;
	logic [1:0] ph = 2'h0;
	logic seen_valid = 1'b0;

	always #20 clk_sys = ~clk_sys;
	// raw source: repeating 4-bit pattern, one bit per clock
	always @(posedge clk_sys)
	begin
		ph <= ph + 2'h1;
		raw_bit <= pat[ph];
	end
	always @(negedge clk_sys)
		if (rnd_valid === 1'b1)
			seen_valid = 1'b1;

	trgh_top uut (.clk_sys(clk_sys), .reset(reset), .gen_enable(gen_enable), .sw_test_fail(sw_test_fail),
		.raw_bit(raw_bit), .rnd_ready(rnd_ready), .rnd_valid(rnd_valid), .rnd_data(rnd_data),
		.rnd_fail(rnd_fail), .rnd_busy(rnd_busy));
	trgh_consumer cpu (.clk_sys(clk_sys), .reset(reset), .stall(stall), .rnd_valid(rnd_valid),
		.rnd_data(rnd_data), .rnd_ready(rnd_ready), .n_words(n_words), .last_word(last_word));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(negedge clk_sys);
	endtask

	// enable from off; sampling on the falling edge keeps clear of updates
	task automatic start(input logic [3:0] p);
		@(posedge clk_sys);
		pat <= p;
		gen_enable <= 1'b1;
		seen_valid = 1'b0;
		n = 0;
	endtask

	task automatic stop();
		@(posedge clk_sys);
		gen_enable <= 1'b0;
		cyc(3);
	endtask

	task automatic wait_valid(input int lim);
		while (rnd_valid !== 1'b1 && n < lim)
		begin
			cyc(1);
			n++;
		end
		// running out of time counts against the run
		check(rnd_valid, 1'b1, "no word before limit");
	endtask

	task automatic t_stuck_start();
		start(4'hf);
		cyc(300);
		check(seen_valid, 1'b0, "output while source dead");
		check(rnd_fail, 1'b1, "dead source not flagged");
		stop();
		$display("test done: stuck at start-up");
	endtask

	task automatic t_good_start();
		start(4'ha);
		cyc(10);
		check(rnd_busy, 1'b1, "no start-up test");
		n = 10;
		wait_valid(3000);
		check(n >= 1024 && n < 3000, 1'b1, "first word timing");
		check(rnd_data == 32'h0 || rnd_data == 32'hffffffff, 1'b1, "word not debiased");
		check(rnd_fail, 1'b0, "good source flagged");
		$display("test done: good start-up");
	endtask

	// stall lets words pile up just short of a full queue, then the drain must keep delivering
	task automatic t_stall();
		int w0;
		@(posedge clk_sys);
		stall <= 1'b1;
		cyc(2000);
		w0 = n_words;
		@(posedge clk_sys);
		stall <= 1'b0;
		cyc(200);
		check(n_words > w0 + 10, 1'b1, "drain after stall");
		$display("test done: stall and drain");
	endtask

	task automatic t_retest();
		logic prev;
		prev = rnd_busy;
		n = 0;
		while (!(rnd_busy === 1'b1 && prev === 1'b0) && n < 26000)
		begin
			prev = rnd_busy;
			cyc(1);
			n++;
		end
		check(n < 26000, 1'b1, "no periodic retest");
		cyc(1100);
		check(rnd_fail, 1'b0, "retest failed good source");
		$display("test done: periodic retest");
	endtask

	task automatic t_stuck_run();
		@(posedge clk_sys);
		pat <= 4'hf;
		cyc(100);
		check(rnd_fail, 1'b1, "dead source in run");
		seen_valid = 1'b0;
		cyc(50);
		check(seen_valid, 1'b0, "output after dead source");
		stop();
		$display("test done: stuck in run");
	endtask

	task automatic t_biased();
		start(4'h1);
		cyc(1300);
		check(seen_valid, 1'b0, "output with biased source");
		check(rnd_fail, 1'b1, "bias not flagged");
		stop();
		$display("test done: biased source");
	endtask

	task automatic t_sw_fail();
		start(4'ha);
		wait_valid(3000);
		@(posedge clk_sys);
		sw_test_fail <= 1'b1;
		@(posedge clk_sys);
		sw_test_fail <= 1'b0;
		cyc(3);
		check({rnd_fail, rnd_valid}, 2'b10, "software fail ignored");
		stop();
		start(4'ha);
		cyc(1500);
		check({rnd_fail, seen_valid}, 2'b10, "generator came back");
		@(posedge clk_sys);
		reset <= 1'b1;
		gen_enable <= 1'b0;
		cyc(4);
		check({rnd_fail, rnd_valid, rnd_busy}, 3'b000, "reset values");
		@(posedge clk_sys);
		reset <= 1'b0;
		$display("test done: software fail");
	endtask

	// queue depth seen from the pins: fill while stalled, silence the source, count the drain
	// the quiet pattern makes only equal pairs for the pair phase that the first word shows
	task automatic t_fifo();
		int w0;
		logic [31:0] w;
		start(4'ha);
		wait_valid(3000);
		w = rnd_data;
		@(posedge clk_sys);
		stall <= 1'b1;
		cyc(2);
		seen_valid = 1'b0;
		w0 = n_words;
		cyc(2400);
		check(seen_valid, 1'b0, "word offered to a stalled reader");
		@(posedge clk_sys);
		pat <= w[0] ? 4'h6 : 4'hc;
		cyc(20);
		@(posedge clk_sys);
		stall <= 1'b0;
		cyc(200);
		check(n_words - w0, trgh_pkg::FIFO_DEPTH, "queue depth through the top");
		check(last_word, {32{w[0]}}, "drained word not debiased");
		check(rnd_fail, 1'b0, "quiet source flagged");
		stop();
		$display("test done: queue fill and drain");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		cyc(4);
		check({rnd_valid, rnd_fail, rnd_busy}, 3'b000, "outputs in reset");
		@(posedge clk_sys);
		reset <= 1'b0;
		t_stuck_start();
		t_good_start();
		t_stall();
		t_retest();
		t_stuck_run();
		t_biased();
		t_sw_fail();
		t_fifo();
		end_of_test();
	end

	// watchdog: all scenarios together stay well under this many cycles
	initial
	begin
		#(40 * 80000);
		n_mismatch++;
		end_of_test();
	end
endmodule
